/* logic/engine_map.svh */
// Address map, field positions, encodings and timing counts of the pattern engine.
// Assumes inclusion by bare name from design files only.
`ifndef ENGINE_MAP_SVH
`define ENGINE_MAP_SVH

// ****************************************
// Register offsets (byte addresses), store select, field bit positions and reset values
// ****************************************
`define CTRL_OFS 8'h00
`define PC_OFS 8'h04
`define STAT_OFS 8'h08
`define BRIGHT_OFS 8'h0c
`define MEM_SEL 2'b01
`define CTRL_LOG_BIT 2
`define STAT_BUSY_BIT 1
`define STAT_PEND_LSB 4
`define CTRL_RESET 2'h0
`define MEM_RESET 16'h0000

// ****************************************
// Instruction encodings
// ****************************************
`define SETB_UPPER 8'h40
`define OP_BRANCH 2'b01
`define OP_END 2'b10
`define OP_TRIG 2'b11

// ****************************************
// Timing
// ****************************************
`define SYS_CLK_HZ 250000000
`define PROG_CLK_HZ 32768
`define PROG_TICK_CYCLES (`SYS_CLK_HZ / `PROG_CLK_HZ)
`define PRESCALE_FAST 16
`define PRESCALE_SLOW 512
`define SHORT_INSTR_TICKS 15'h0010

`endif

/* logic/engine_pkg.sv */
// Types shared by the pattern engine files.
// Assumes nothing beyond a SystemVerilog compiler.
package engine_pkg;

    typedef enum logic [1:0] {CONTROL_FIELD_A_HOLD, CONTROL_FIELD_A_STEP, CONTROL_FIELD_A_RUN, CONTROL_FIELD_A_ONCE} control_field_a_mode_e;

    typedef enum {ST_IDLE, ST_FETCH, ST_CONTROL_FIELD_A, ST_RUN} control_field_a_state_e;

    typedef enum {K_RAMP, K_SET, K_RESTART, K_BRANCH, K_END, K_TRIG} instr_kind_e;

endpackage

/* logic/prog_tick.sv */
// Divider that makes the program clock as a one-cycle enable.
// Assumes a single system clock with synchronous active-high reset.
`timescale 1ns/1ps

module prog_tick #(
    parameter int CYCLES = 7629
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o
);

    // ****************************************
    // Counter
    // ****************************************
    logic [15:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_q == 16'(CYCLES - 1)) begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick_o <= 1'b0;
        end
    end

endmodule

/* logic/bright_scale.sv */
// Maps an 8-bit brightness code onto a logarithmic output curve.
// Assumes the caller registers the result.
`timescale 1ns/1ps

module bright_scale (
    input wire logic [7:0] code_i,
    output logic [7:0] level_o
);

    // ****************************************
    // Mantissa shifted by exponent
    // ****************************************
    logic [12:0] wide;

    always_comb begin
        wide = 13'({1'b1, code_i[4:0]}) << code_i[7:5];
        level_o = (code_i == 8'h00) ? 8'h00 : wide[12:5];
    end

endmodule

/* logic/pattern_engine.sv */
// Instruction executor of one lighting-pattern engine with its program store and APB registers.
// Assumes APB master on clk_i and trigger pulses from sibling engines synchronous to clk_i.
`timescale 1ns/1ps
`include "engine_map.svh"

// Notes on behaviour
// - Ramp steps brightness by one, sign sets direction
// - Prescale picks divide by 16 or 512
// - Step time multiplies period; zero means set or restart
// - Steps equal increment plus one; zero waits
// - Ramp clamps at 0/255, runs full length
// - Scale bit picks linear or logarithmic output
// - Set instruction loads eight-bit brightness directly
// - Set, restart, branch, end take sixteen ticks
// - All-zero word jumps back to location zero
// - Program store resets to all-zero words
// - Branch loads target and repeats counted loops
// - Loop count zero loops forever
// - Each branch keeps its own loop counter
// - End clears counter and sets hold
// - End with int bit sets status flag
// - Trigger selects engines to await and signal
// - End reset bit forces brightness to zero
// - Triggers latched; wait clears them, sixteen ticks
// - Counter wraps from fifteen to zero
module pattern_engine #(
    parameter int TICK_CYCLES = `PROG_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [2:0] trig_in_i,
    output logic [2:0] trig_out_o,
    output logic [7:0] pwm_o
);

    // ****************************************
    // Declarations
    // ****************************************
    engine_pkg::control_field_a_state_e state_q;
    engine_pkg::instr_kind_e kind_q, kind_d;
    engine_pkg::control_field_a_mode_e ctrl_q, mode_q;
    logic [15:0] prog_q [16];
    logic [5:0] loop_q [16];
    logic [15:0] instr_q;
    logic [3:0] pc_q, pc_d;
    logic [14:0] cnt_q, step_ticks;
    logic [6:0] steps_q;
    logic [7:0] bright_q, scaled;
    logic log_q, irq_q, tick, at_end, fin, taken, trig_ok;
    logic [2:0] pend_q;
    logic acc, wr, rd, hit;
    logic [31:0] rdata;

    prog_tick #(.CYCLES(TICK_CYCLES)) u_tick (.clk_i(clk_i), .rst_i(rst_i), .tick_o(tick));
    bright_scale u_scale (.code_i(bright_q), .level_o(scaled));

    // ****************************************
    // Decode
    // ****************************************
    always_comb begin
        if (!instr_q[15]) begin
            if (instr_q[13:8] != 6'h00) begin
                kind_d = engine_pkg::K_RAMP;
            end else if (instr_q[15:8] == `SETB_UPPER) begin
                kind_d = engine_pkg::K_SET;
            end else begin
                kind_d = engine_pkg::K_RESTART;
            end
        end else if (instr_q[14:13] == `OP_BRANCH) begin
            kind_d = engine_pkg::K_BRANCH;
        end else if (instr_q[14:13] == `OP_END) begin
            kind_d = engine_pkg::K_END;
        end else begin
            kind_d = engine_pkg::K_TRIG;
        end
    end

    always_comb begin
        step_ticks = instr_q[14] ? 15'(instr_q[13:8] * `PRESCALE_SLOW) : 15'(instr_q[13:8] * `PRESCALE_FAST);
        trig_ok = (pend_q & instr_q[9:7]) == instr_q[9:7];
        taken = (instr_q[12:7] == 6'h00) || (loop_q[pc_q] < instr_q[12:7]);
        at_end = (state_q == engine_pkg::ST_RUN) && tick && (cnt_q == 15'h0001);
        fin = at_end && (kind_q != engine_pkg::K_RAMP || steps_q == 7'h00)
            && (kind_q != engine_pkg::K_TRIG || trig_ok);
        unique case (kind_q)
            engine_pkg::K_RESTART: pc_d = 4'h0;
            engine_pkg::K_END: pc_d = 4'h0;
            engine_pkg::K_BRANCH: pc_d = taken ? instr_q[3:0] : pc_q + 4'h1;
            engine_pkg::K_RAMP, engine_pkg::K_SET, engine_pkg::K_TRIG: pc_d = pc_q + 4'h1;
        endcase
        if (mode_q == engine_pkg::CONTROL_FIELD_A_ONCE && kind_q != engine_pkg::K_END) begin
            pc_d = pc_q;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= engine_pkg::ST_IDLE;
            instr_q <= 16'h0000;
            kind_q <= engine_pkg::K_RESTART;
            mode_q <= engine_pkg::CONTROL_FIELD_A_HOLD;
            cnt_q <= 15'h0000;
            steps_q <= 7'h00;
        end else begin
            unique case (state_q)
                engine_pkg::ST_IDLE: begin
                    if (ctrl_q != engine_pkg::CONTROL_FIELD_A_HOLD) begin
                        state_q <= engine_pkg::ST_FETCH;
                    end
                end
                engine_pkg::ST_FETCH: begin
                    instr_q <= prog_q[pc_q];
                    mode_q <= ctrl_q;
                    state_q <= engine_pkg::ST_CONTROL_FIELD_A;
                end
                engine_pkg::ST_CONTROL_FIELD_A: begin
                    kind_q <= kind_d;
                    steps_q <= instr_q[6:0];
                    cnt_q <= (kind_d == engine_pkg::K_RAMP) ? step_ticks : `SHORT_INSTR_TICKS;
                    state_q <= engine_pkg::ST_RUN;
                end
                engine_pkg::ST_RUN: begin
                    if (fin) begin
                        if (ctrl_q == engine_pkg::CONTROL_FIELD_A_RUN && mode_q == engine_pkg::CONTROL_FIELD_A_RUN
                            && kind_q != engine_pkg::K_END) begin
                            state_q <= engine_pkg::ST_FETCH;
                        end else begin
                            state_q <= engine_pkg::ST_IDLE;
                        end
                    end else if (at_end && kind_q == engine_pkg::K_RAMP) begin
                        steps_q <= steps_q - 7'h01;
                        cnt_q <= step_ticks;
                    end else if (tick && cnt_q > 15'h0001) begin
                        cnt_q <= cnt_q - 15'h0001;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Program counter and loop counters
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_q <= 4'h0;
        end else if (fin) begin
            pc_q <= pc_d;
        end else if (wr && paddr_i == `PC_OFS && ctrl_q == engine_pkg::CONTROL_FIELD_A_HOLD
                     && state_q == engine_pkg::ST_IDLE) begin
            pc_q <= pwdata_i[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 16; i++) begin
                loop_q[i] <= 6'h00;
            end
        end else if (fin && kind_q == engine_pkg::K_BRANCH && instr_q[12:7] != 6'h00) begin
            loop_q[pc_q] <= taken ? loop_q[pc_q] + 6'h01 : 6'h00;
        end
    end

    // ****************************************
    // Brightness
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bright_q <= 8'h00;
        end else if (state_q == engine_pkg::ST_CONTROL_FIELD_A && kind_d == engine_pkg::K_SET) begin
            bright_q <= instr_q[7:0];
        end else if (fin && kind_q == engine_pkg::K_END && instr_q[11]) begin
            bright_q <= 8'h00;
        end else if (at_end && kind_q == engine_pkg::K_RAMP && instr_q[6:0] != 7'h00) begin
            if (!instr_q[7] && bright_q != 8'hff) begin
                bright_q <= bright_q + 8'h01;
            end else if (instr_q[7] && bright_q != 8'h00) begin
                bright_q <= bright_q - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_o <= 8'h00;
        end else begin
            pwm_o <= log_q ? scaled : bright_q;
        end
    end

    // ****************************************
    // Triggers and end flag
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 3'h0;
            trig_out_o <= 3'h0;
        end else begin
            pend_q <= (pend_q & ~((fin && kind_q == engine_pkg::K_TRIG) ? instr_q[9:7] : 3'h0))
                      | trig_in_i;
            trig_out_o <= (state_q == engine_pkg::ST_CONTROL_FIELD_A && kind_d == engine_pkg::K_TRIG) ? instr_q[3:1] : 3'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else if (fin && kind_q == engine_pkg::K_END && instr_q[12]) begin
            irq_q <= 1'b1;
        end else if (rd && paddr_i == `STAT_OFS) begin
            irq_q <= 1'b0;
        end
    end

    // ****************************************
    // Control field
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= engine_pkg::control_field_a_mode_e'(`CTRL_RESET);
            log_q <= 1'b0;
        end else if (wr && paddr_i == `CTRL_OFS) begin
            ctrl_q <= engine_pkg::control_field_a_mode_e'(pwdata_i[1:0]);
            log_q <= pwdata_i[`CTRL_LOG_BIT];
        end else if (fin && (kind_q == engine_pkg::K_END || mode_q == engine_pkg::CONTROL_FIELD_A_STEP
                             || mode_q == engine_pkg::CONTROL_FIELD_A_ONCE)) begin
            ctrl_q <= engine_pkg::CONTROL_FIELD_A_HOLD;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    always_comb begin
        acc = psel_i && penable_i && !pready_o;
        wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
        rd = psel_i && penable_i && pready_o && !pwrite_i;
        hit = 1'b1;
        rdata = 32'h0000_0000;
        if (paddr_i[7:6] == `MEM_SEL && paddr_i[1:0] == 2'b00) begin
            rdata = {16'h0000, prog_q[paddr_i[5:2]]};
        end else if (paddr_i == `CTRL_OFS) begin
            rdata = {29'h0, log_q, ctrl_q};
        end else if (paddr_i == `PC_OFS) begin
            rdata = {28'h0, pc_q};
        end else if (paddr_i == `STAT_OFS) begin
            rdata = {25'h0, pend_q, 2'b00, state_q != engine_pkg::ST_IDLE, irq_q};
        end else if (paddr_i == `BRIGHT_OFS) begin
            rdata = {16'h0000, pwm_o, bright_q};
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= acc;
            pslverr_o <= acc && !hit;
            prdata_o <= (acc && !pwrite_i) ? rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 16; i++) begin
                prog_q[i] <= `MEM_RESET;
            end
        end else if (wr && paddr_i[7:6] == `MEM_SEL) begin
            prog_q[paddr_i[5:2]] <= pwdata_i[15:0];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence ramp_up_s;
        at_end && kind_q == engine_pkg::K_RAMP && instr_q[6:0] != 7'h00 && !instr_q[7];
    endsequence
    sequence ramp_down_s;
        at_end && kind_q == engine_pkg::K_RAMP && instr_q[6:0] != 7'h00 && instr_q[7];
    endsequence

    ramp_up_step_a: assert property (ramp_up_s ##0 (bright_q != 8'hff) |=>
        bright_q == $past(bright_q) + 8'h01) else $error("ramp up did not add one");
    ramp_clamp_a: assert property (ramp_down_s ##0 (bright_q == 8'h00) |=>
        bright_q == 8'h00 && ((state_q == engine_pkg::ST_RUN) == ($past(steps_q) != 7'h00)))
        else $error("ramp left zero or ended early");
    step_len_a: assert property (state_q == engine_pkg::ST_CONTROL_FIELD_A && kind_d == engine_pkg::K_RAMP |=>
        cnt_q == 15'($past(instr_q[13:8]) * ($past(instr_q[14]) ? 512 : 16))) else $error("step period wrong");
    wait_still_a: assert property (state_q == engine_pkg::ST_RUN && kind_q == engine_pkg::K_RAMP
        && instr_q[6:0] == 7'h00 |=> $stable(bright_q) || state_q != engine_pkg::ST_RUN) else $error("wait moved");
    short_len_a: assert property (state_q == engine_pkg::ST_CONTROL_FIELD_A && kind_d != engine_pkg::K_RAMP |=>
        cnt_q == 15'h0010) else $error("short instruction not sixteen ticks");
    lin_map_a: assert property (!log_q ##1 !log_q |-> pwm_o == $past(bright_q))
        else $error("linear output mismatch");
    set_load_a: assert property (state_q == engine_pkg::ST_CONTROL_FIELD_A && kind_d == engine_pkg::K_SET |=>
        bright_q == $past(instr_q[7:0])) else $error("set brightness not loaded");
    end_hold_a: assert property (fin && kind_q == engine_pkg::K_END && !(wr && paddr_i == `CTRL_OFS) |=>
        pc_q == 4'h0 ##0 ctrl_q == engine_pkg::CONTROL_FIELD_A_HOLD ##1 state_q == engine_pkg::ST_IDLE)
        else $error("end did not hold");
    end_flag_a: assert property (fin && kind_q == engine_pkg::K_END && instr_q[12] |=> irq_q [*2])
        else $error("end flag not set");
    flag_keep_a: assert property (irq_q && !(rd && paddr_i == `STAT_OFS) |=> irq_q)
        else $error("flag cleared without read");
    inf_loop_a: assert property (fin && kind_q == engine_pkg::K_BRANCH && instr_q[12:7] == 6'h00
        && mode_q != engine_pkg::CONTROL_FIELD_A_ONCE |=> pc_q == $past(instr_q[3:0])) else $error("endless branch fell through");
    trig_hold_a: assert property (at_end && kind_q == engine_pkg::K_TRIG && !trig_ok |=>
        state_q == engine_pkg::ST_RUN) else $error("trigger wait ended early");

endmodule

/* bench/trigger_peers.sv */
// Model of the sibling engines that trade trigger pulses with the pattern engine.
// Assumes one clock shared with the engine and a bench that pulses fire_i for one cycle.
`timescale 1ns/1ps

module trigger_peers (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] fire_i,
    input wire logic clear_i,
    input wire logic [2:0] trig_from_engine_i,
    output logic [2:0] trig_to_engine_o,
    output logic [2:0] seen_o
);
    // ****************************************
    // Sent triggers, one cycle per request
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_to_engine_o <= 3'h0;
        end else begin
            trig_to_engine_o <= fire_i;
        end
    end

    // ****************************************
    // Received triggers, latched per engine
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            seen_o <= 3'h0;
        end else begin
            seen_o <= seen_o | trig_from_engine_i;
        end
    end
endmodule

/* bench/tb_led_pattern_instruction_executor.sv */
// Self-checking bench of the pattern engine, driving its APB port and trigger lines.
// Assumes the engine built with a short program tick of four clocks.
`timescale 1ns/1ps

module tb_led_pattern_instruction_executor;
    logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err, clear;
    logic [7:0] paddr_i, pwm_o;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [2:0] trig_in_i, trig_out_o, fire, seen;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0;

    pattern_engine #(.TICK_CYCLES(4)) pattern_engine_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .trig_in_i(trig_in_i),
        .trig_out_o(trig_out_o), .pwm_o(pwm_o));
    trigger_peers trigger_peers_i (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .clear_i(clear),
        .trig_from_engine_i(trig_out_o), .trig_to_engine_o(trig_in_i), .seen_o(seen));

    // ****************************************
    // Clock, cycle count, watchdog
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;
    initial begin
        #200us;
        n_errors++;
        give_verdict();
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        tests_run++;
        if (seen_v !== exp_v) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    task automatic apb(input logic wr_v, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr_v;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp_v);
        apb(1'b0, a, 32'h0);
        check(rd & mask, exp_v);
    endtask
    task automatic prog(input int n, input logic [15:0] w);
        apb(1'b1, 8'h40 + 8'(4 * n), {16'h0, w});
    endtask
    task automatic run_from(input logic [3:0] pc, input logic [31:0] ctrl);
        apb(1'b1, 8'h04, {28'h0, pc});
        apb(1'b1, 8'h00, ctrl);
        t0 = cyc;
    endtask
    task automatic wait_hold();
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h00, 32'h0);
            n++;
        end while (rd[1:0] !== 2'b00 && n < 2000);
        if (n >= 2000) n_errors++;
    endtask
    task automatic in_span(input int lo, input int hi);
        check({31'h0, (cyc - t0 >= lo) && (cyc - t0 <= hi)}, 32'h1);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdc(8'h00, 32'hffffffff, 32'h0);
        rdc(8'h54, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, err}, 32'h1);
        check(32'(pwm_o), 32'h0);
    endtask
    task automatic t_set_end();
        prog(0, 16'h40aa);
        prog(1, 16'hd000);
        run_from(4'h0, 32'h2);
        wait_hold();
        in_span(124, 160);
        rdc(8'h0c, 32'hff, 32'haa);
        check(32'(pwm_o), 32'haa);
        rdc(8'h04, 32'hf, 32'h0);
        repeat (100) @(posedge clk_i);
        rdc(8'h08, 32'h1, 32'h1);
        rdc(8'h08, 32'h1, 32'h0);
    endtask
    task automatic t_ramp();
        prog(0, 16'h40fe);
        prog(1, 16'h0203);
        prog(2, 16'h4200);
        prog(3, 16'hc000);
        run_from(4'h0, 32'h2);
        wait_hold();
        in_span(4730, 4760);
        rdc(8'h0c, 32'hff, 32'hff);
        rdc(8'h08, 32'h1, 32'h0);
    endtask
    task automatic t_branch();
        prog(0, 16'h4000);
        prog(1, 16'h0201);
        prog(2, 16'ha101);
        prog(3, 16'hd000);
        repeat (2) begin
            run_from(4'h0, 32'h2);
            wait_hold();
            in_span(1080, 1110);
            rdc(8'h0c, 32'hff, 32'h06);
        end
    endtask
    task automatic t_wrap();
        prog(0, 16'hd000);
        prog(13, 16'h0000);
        prog(14, 16'h4033);
        prog(15, 16'h0283);
        run_from(4'hE, 32'h2);
        wait_hold();
        rdc(8'h0c, 32'hff, 32'h2f);
        run_from(4'hD, 32'h2);
        wait_hold();
        in_span(124, 160);
        rdc(8'h0c, 32'hff, 32'h2f);
        rdc(8'h08, 32'h1, 32'h1);
    endtask
    task automatic t_forever();
        prog(0, 16'h0201);
        prog(1, 16'ha000);
        prog(2, 16'hd000);
        run_from(4'h0, 32'h2);
        repeat (1200) @(posedge clk_i);
        rdc(8'h00, 32'h3, 32'h2);
        rdc(8'h08, 32'h1, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        repeat (300) @(posedge clk_i);
    endtask
    task automatic t_trigger();
        clear <= 1'b1;
        prog(0, 16'hfcf1);
        prog(1, 16'hfc75);
        prog(2, 16'hd800);
        clear <= 1'b0;
        run_from(4'h0, 32'h2);
        repeat (300) @(posedge clk_i);
        rdc(8'h00, 32'h3, 32'h2);
        check(32'(seen), 32'h0);
        @(posedge clk_i);
        fire <= 3'h1;
        @(posedge clk_i);
        fire <= 3'h0;
        wait_hold();
        check(32'(seen), 32'h2);
        rdc(8'h0c, 32'hff, 32'h0);
        check(32'(pwm_o), 32'h0);
    endtask
    task automatic t_log();
        prog(0, 16'h40aa);
        prog(1, 16'hd000);
        run_from(4'h0, 32'h6);
        wait_hold();
        rdc(8'h0c, 32'hffff, 32'h2aaa);
        check(32'(pwm_o), 32'h2a);
    endtask
    task automatic t_step();
        prog(0, 16'h4002);
        prog(1, 16'h0183);
        run_from(4'h0, 32'h1);
        wait_hold();
        rdc(8'h04, 32'hf, 32'h1);
        rdc(8'h0c, 32'hff, 32'h02);
        run_from(4'h1, 32'h3);
        wait_hold();
        in_span(250, 270);
        rdc(8'h04, 32'hf, 32'h1);
        rdc(8'h0c, 32'hff, 32'h00);
    endtask

    // ****************************************
    // Main sequence and verdict
    // ****************************************
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        fire = 3'h0;
        clear = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_set_end();
        t_ramp();
        t_branch();
        t_wrap();
        t_forever();
        t_trigger();
        t_log();
        t_step();
        give_verdict();
    end
endmodule
